// >>> rtc_core_defines.vh
// Register map, field positions and reset values of the clock/calendar core
`ifndef RTC_CORE_DEFINES_VH
`define RTC_CORE_DEFINES_VH
`define RTC_SEC_ADDR 16'h9100
`define RTC_MIN_ADDR 16'h9101
`define RTC_HOUR_ADDR 16'h9102
`define RTC_DAY_ADDR 16'h9103
`define RTC_CS1_ADDR 16'h9110
`define RTC_CS2_ADDR 16'h9111
`define RTC_BYTE_ADDR(i) ({14'h0000, i, 2'b00})
`define RTC_HALT_BIT 4
`define RTC_CORR_BIT 7
`define RTC_A2F_BIT 5
`define RTC_A1F_BIT 4
`define RTC_STF_BIT 3
`define RTC_A2E_BIT 2
`define RTC_A1E_BIT 1
`define RTC_SIE_BIT 0
`define RTC_VALID_BIT 7
`define RTC_CS2_WMASK 8'h07
`define RTC_SEC_MAX 8'h59
`define RTC_HOUR_MAX 8'h23
`define RTC_DAY_FIRST 8'h01
`define RTC_ZERO8 8'h00
`define RTC_FEB 8'h02
`define RTC_DAYS_28 8'h28
`define RTC_DAYS_29 8'h29
`define RTC_DAYS_30 8'h30
`define RTC_DAYS_31 8'h31
`define RTC_APR 8'h04
`define RTC_JUN 8'h06
`define RTC_SEP 8'h09
`define RTC_NOV 8'h11
`define RTC_BCD_LIMIT 4'hA
`define RTC_YEAR_DEF 8'h00
`define RTC_MONTH_DEF 8'h01
`endif

// >>> rtc_time_status_control.v
// Clock/calendar core: time counters, run control, interrupt flags, APB slave
// Operation
// - Any time register write sets halt flag and stops timekeeping
// - Software clears halt to restart; tick still forwarded to I/O while halted
// - Unassigned control/status bits read zero and ignore writes
// - Corrected impossible write sets correction flag and interrupt; software clears
// - Alarm 2 event sets sticky flag only while its interrupt is enabled; software only clears it
// - Alarm 1 event sets sticky flag only while its interrupt is enabled; software only clears it
// - Seconds-timer event sets sticky flag; software only clears it
// - Bit 2 enables alarm 2 interrupt, bit 1 alarm 1 interrupt
// - Bit 0 enables the seconds-timer interrupt
// - Alarms fire only on rising tick edge seen by system clock
// - Seconds bit 7 flags unreliable time; set at power-up, software clears
// - Seconds hold BCD 0 to 59 in bits 6..0
// - Minutes hold BCD 0 to 59, bit 7 reads zero
// - Hours hold BCD 0 to 23, upper bits read zero
// - Days hold BCD 1 to 31, upper bits read zero
// - Year 00 is not a leap year
// - Illegal written values become first valid value in the same cycle that sets the flag
// - Enabled alarm fires when time matches alarm with seconds zero
// - Clearing halt reopens the tick gate and resumes from written values
`timescale 1ns/1ns
`include "rtc_core_defines.vh"
`default_nettype none
module rtc_time_status_control (
  input wire core_clk_i,
  input wire srst_i,
  input wire [31:0] paddr_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output wire pslverr_o,
  input wire one_hertz_tick_i,
  input wire alarm1_match_i,
  input wire alarm2_match_i,
  input wire seconds_timer_event_i,
  input wire [7:0] month_i,
  input wire [7:0] year_i,
  output wire day_rollover_o,
  output reg multipurpose_io_o,
  output wire irq_o
);
  reg tick_s1_reg;
  reg tick_s2_reg;
  reg tick_prev_reg;
  reg [7:0] sec_reg;
  reg [7:0] min_reg;
  reg [7:0] hour_reg;
  reg [7:0] day_reg;
  reg clock_invalid_flag_reg;
  reg halt_reg;
  reg date_correction_flag_reg;
  reg second_alarm_flag_reg;
  reg first_alarm_flag_reg;
  reg seconds_timer_flag_reg;
  reg second_alarm_irq_enable_reg;
  reg first_alarm_irq_enable_reg;
  reg seconds_irq_enable_reg;
  reg rollover_reg;
  wire tick_rise;
  wire wr;
  wire rd;
  wire [7:0] wb;
  wire [7:0] wb_sec;
  reg [7:0] fixed;
  wire wr_time;
  wire count_en;
  wire alarm_slot;
  wire wr_cs2;
  wire [7:0] month_end;
  wire sec_wrap;
  wire min_wrap;
  wire hour_wrap;
  wire day_wrap;

  // Valid packed BCD within 0..max
  function bcd_ok;
    input [7:0] v;
    input [7:0] mx;
    begin
      bcd_ok = (v[3:0] < `RTC_BCD_LIMIT) && (v[7:4] < `RTC_BCD_LIMIT) && (v <= mx);
    end
  endfunction

  // One of the four time registers; any write there halts the clock
  function is_time_addr;
    input [31:0] a;
    begin
      if (a == `RTC_BYTE_ADDR(`RTC_SEC_ADDR))
      begin
        is_time_addr = 1'b1;
      end
      else if (a == `RTC_BYTE_ADDR(`RTC_MIN_ADDR))
      begin
        is_time_addr = 1'b1;
      end
      else if (a == `RTC_BYTE_ADDR(`RTC_HOUR_ADDR))
      begin
        is_time_addr = 1'b1;
      end
      else
      begin
        is_time_addr = (a == `RTC_BYTE_ADDR(`RTC_DAY_ADDR));
      end
    end
  endfunction

  // BCD increment, no range check
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
      begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end
      else
      begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  // Last day of a month, leap year by the two-digit year
  function [7:0] last_day;
    input [7:0] mo;
    input [7:0] yr;
    reg leap;
    begin
      leap = (yr != `RTC_YEAR_DEF) && ((yr[4] ^ yr[1]) == 1'b0) && (yr[0] == 1'b0);
      if (mo == `RTC_FEB)
      begin
        last_day = leap ? `RTC_DAYS_29 : `RTC_DAYS_28;
      end
      else if (mo == `RTC_APR || mo == `RTC_JUN || mo == `RTC_SEP || mo == `RTC_NOV)
      begin
        last_day = `RTC_DAYS_30;
      end
      else
      begin
        last_day = `RTC_DAYS_31;
      end
    end
  endfunction

  assign tick_rise = tick_s2_reg & ~tick_prev_reg;
  // Zero-wait slave: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & ~penable_i & ~pwrite_i;
  assign wb = pwdata_i[7:0];
  assign wr_cs2 = wr && (paddr_i == `RTC_BYTE_ADDR(`RTC_CS2_ADDR));
  assign wr_time = wr && is_time_addr(paddr_i);
  assign wb_sec = {1'b0, wb[6:0]};
  assign month_end = last_day(month_i, year_i);
  // Counting only with the gate open; halted counters ignore ticks
  assign count_en = tick_rise && !halt_reg;
  assign sec_wrap = count_en && (sec_reg[6:0] == `RTC_SEC_MAX);
  // Alarm slot: tick edge while seconds read zero
  assign alarm_slot = tick_rise && (sec_reg[6:0] == `RTC_ZERO8);
  assign min_wrap = sec_wrap && (min_reg == `RTC_SEC_MAX);
  assign hour_wrap = min_wrap && (hour_reg == `RTC_HOUR_MAX);
  assign day_wrap = hour_wrap && (day_reg == month_end);
  assign day_rollover_o = rollover_reg;
  // Written value, replaced by first valid value when illegal
  always @*
  begin
    if (paddr_i == `RTC_BYTE_ADDR(`RTC_SEC_ADDR))
    begin
      fixed = bcd_ok(wb_sec, `RTC_SEC_MAX) ? wb_sec : `RTC_ZERO8;
    end
    else if (paddr_i == `RTC_BYTE_ADDR(`RTC_MIN_ADDR))
    begin
      fixed = bcd_ok(wb, `RTC_SEC_MAX) ? wb : `RTC_ZERO8;
    end
    else if (paddr_i == `RTC_BYTE_ADDR(`RTC_HOUR_ADDR))
    begin
      fixed = bcd_ok(wb, `RTC_HOUR_MAX) ? wb : `RTC_ZERO8;
    end
    else
    begin
      fixed = (bcd_ok(wb, month_end) && wb != `RTC_ZERO8) ? wb : `RTC_DAY_FIRST;
    end
  end

  // Tick synchroniser; only the second stage is read
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_prev_reg <= 1'b0;
      multipurpose_io_o <= 1'b0;
    end
    else
    begin
      tick_s1_reg <= one_hertz_tick_i;
      tick_s2_reg <= tick_s1_reg;
      tick_prev_reg <= tick_s2_reg;
      multipurpose_io_o <= tick_s2_reg;
    end
  end

  // Time counters and run control
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      sec_reg <= `RTC_ZERO8;
      min_reg <= `RTC_ZERO8;
      hour_reg <= `RTC_ZERO8;
      day_reg <= `RTC_DAY_FIRST;
      clock_invalid_flag_reg <= 1'b1;
      halt_reg <= 1'b1;
      rollover_reg <= 1'b0;
    end
    else
    begin
      rollover_reg <= day_wrap;
      if (wr_time)
      begin
        halt_reg <= 1'b1;
        if (paddr_i == `RTC_BYTE_ADDR(`RTC_SEC_ADDR))
        begin
          sec_reg <= fixed;
          clock_invalid_flag_reg <= clock_invalid_flag_reg & wb[`RTC_VALID_BIT];
        end
        else if (paddr_i == `RTC_BYTE_ADDR(`RTC_MIN_ADDR))
        begin
          min_reg <= fixed;
        end
        else if (paddr_i == `RTC_BYTE_ADDR(`RTC_HOUR_ADDR))
        begin
          hour_reg <= fixed;
        end
        else
        begin
          day_reg <= fixed;
        end
      end
      else
      begin
        if (wr && (paddr_i == `RTC_BYTE_ADDR(`RTC_CS1_ADDR)))
        begin
          halt_reg <= wb[`RTC_HALT_BIT];
        end
        if (count_en)
        begin
          sec_reg <= sec_wrap ? `RTC_ZERO8 : bcd_inc(sec_reg);
          if (sec_wrap)
          begin
            min_reg <= min_wrap ? `RTC_ZERO8 : bcd_inc(min_reg);
          end
          if (min_wrap)
          begin
            hour_reg <= hour_wrap ? `RTC_ZERO8 : bcd_inc(hour_reg);
          end
          if (hour_wrap)
          begin
            day_reg <= day_wrap ? `RTC_DAY_FIRST : bcd_inc(day_reg);
          end
        end
      end
    end
  end

  // Flags and enables; a hardware set wins over a same-cycle clear
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      date_correction_flag_reg <= 1'b0;
      second_alarm_flag_reg <= 1'b0;
      first_alarm_flag_reg <= 1'b0;
      seconds_timer_flag_reg <= 1'b0;
      second_alarm_irq_enable_reg <= 1'b0;
      first_alarm_irq_enable_reg <= 1'b0;
      seconds_irq_enable_reg <= 1'b0;
    end
    else
    begin
      if (wr_time && fixed != ((paddr_i == `RTC_BYTE_ADDR(`RTC_SEC_ADDR)) ? wb_sec : wb))
      begin
        date_correction_flag_reg <= 1'b1;
      end
      else if (wr_cs2 && !wb[`RTC_CORR_BIT])
      begin
        date_correction_flag_reg <= 1'b0;
      end
      // Flag only an enabled alarm, so a later enable cannot fire a stale match
      if (alarm_slot && alarm2_match_i && second_alarm_irq_enable_reg)
      begin
        second_alarm_flag_reg <= 1'b1;
      end
      else if (wr_cs2 && !wb[`RTC_A2F_BIT])
      begin
        second_alarm_flag_reg <= 1'b0;
      end
      if (alarm_slot && alarm1_match_i && first_alarm_irq_enable_reg)
      begin
        first_alarm_flag_reg <= 1'b1;
      end
      else if (wr_cs2 && !wb[`RTC_A1F_BIT])
      begin
        first_alarm_flag_reg <= 1'b0;
      end
      if (seconds_timer_event_i)
      begin
        seconds_timer_flag_reg <= 1'b1;
      end
      else if (wr_cs2 && !wb[`RTC_STF_BIT])
      begin
        seconds_timer_flag_reg <= 1'b0;
      end
      if (wr_cs2)
      begin
        second_alarm_irq_enable_reg <= wb[`RTC_A2E_BIT];
        first_alarm_irq_enable_reg <= wb[`RTC_A1E_BIT];
        seconds_irq_enable_reg <= wb[`RTC_SIE_BIT];
      end
    end
  end

  assign irq_o = date_correction_flag_reg |
                 (second_alarm_flag_reg & second_alarm_irq_enable_reg) |
                 (first_alarm_flag_reg & first_alarm_irq_enable_reg) |
                 (seconds_timer_flag_reg & seconds_irq_enable_reg);

  // Read data captured in setup, stable through the access cycle
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      prdata_o <= 32'h00000000;
    end
    else if (rd)
    begin
      if (paddr_i == `RTC_BYTE_ADDR(`RTC_SEC_ADDR))
      begin
        prdata_o <= {24'h000000, clock_invalid_flag_reg, sec_reg[6:0]};
      end
      else if (paddr_i == `RTC_BYTE_ADDR(`RTC_MIN_ADDR))
      begin
        prdata_o <= {24'h000000, min_reg};
      end
      else if (paddr_i == `RTC_BYTE_ADDR(`RTC_HOUR_ADDR))
      begin
        prdata_o <= {24'h000000, hour_reg};
      end
      else if (paddr_i == `RTC_BYTE_ADDR(`RTC_DAY_ADDR))
      begin
        prdata_o <= {24'h000000, day_reg};
      end
      else if (paddr_i == `RTC_BYTE_ADDR(`RTC_CS1_ADDR))
      begin
        prdata_o <= {27'h0000000, halt_reg, 4'h0};
      end
      else if (paddr_i == `RTC_BYTE_ADDR(`RTC_CS2_ADDR))
      begin
        prdata_o <= {24'h000000, date_correction_flag_reg, 1'b0, second_alarm_flag_reg,
                     first_alarm_flag_reg, seconds_timer_flag_reg,
                     second_alarm_irq_enable_reg, first_alarm_irq_enable_reg,
                     seconds_irq_enable_reg};
      end
      else
      begin
        prdata_o <= 32'h00000000;
      end
    end
  end
endmodule // rtc_time_status_control
`default_nettype wire

// >>> rtc_chk.sv
// Port-level assertions for the clock/calendar core
`timescale 1ns/1ns
`include "rtc_core_defines.vh"
`default_nettype none
module rtc_chk (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [31:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic one_hertz_tick_i,
  input wire logic day_rollover_o,
  input wire logic multipurpose_io_o,
  input wire logic irq_o
);
  localparam logic [31:0] A_CS1 = `RTC_BYTE_ADDR(`RTC_CS1_ADDR);
  localparam logic [31:0] A_CS2 = `RTC_BYTE_ADDR(`RTC_CS2_ADDR);
  localparam logic [31:0] A_MIN = `RTC_BYTE_ADDR(`RTC_MIN_ADDR);
  localparam logic [31:0] A_HR = `RTC_BYTE_ADDR(`RTC_HOUR_ADDR);
  localparam logic [31:0] A_DAY = `RTC_BYTE_ADDR(`RTC_DAY_ADDR);
  wire rd = psel_i && !penable_i && !pwrite_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_bus_ready: assert property (pready_o && !pslverr_o) else $error("bus answer not immediate");
  a_rdata_upper: assert property (prdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_cs1_unused: assert property (rd && paddr_i == A_CS1 |=> (prdata_o[7:0] & 8'hEF) == 8'h00)
    else $error("run control unused bit set");
  a_cs2_unused: assert property (rd && paddr_i == A_CS2 |=> !prdata_o[6])
    else $error("flag register bit 6 set");
  a_min_msb: assert property (rd && paddr_i == A_MIN |=> !prdata_o[7])
    else $error("minute bit 7 set");
  a_hour_upper: assert property (rd && paddr_i == A_HR |=> prdata_o[7:6] == 2'b00)
    else $error("hour upper bits set");
  a_day_upper: assert property (rd && paddr_i == A_DAY |=> prdata_o[7:6] == 2'b00)
    else $error("day upper bits set");
  a_irq_clear: assert property ($fell(irq_o) |->
    $past(psel_i && penable_i && pwrite_i && paddr_i == A_CS2))
    else $error("interrupt dropped without flag write");
  a_tick_fwd: assert property ($rose(one_hertz_tick_i) |-> ##[1:5] multipurpose_io_o)
    else $error("tick not forwarded");
  a_tick_low: assert property ($fell(one_hertz_tick_i) |-> ##[1:5] !multipurpose_io_o)
    else $error("tick low not forwarded");
  a_roll_pulse: assert property (day_rollover_o |=> !day_rollover_o) else $error("long rollover");
  c_irq: cover property ($rose(irq_o));
  c_roll: cover property (day_rollover_o);
  c_cs1: cover property (rd && paddr_i == A_CS1);
endmodule // rtc_chk
`default_nettype wire

// >>> tick_event_source.sv
// Tick, alarm-match and seconds-timer source facing the core
`timescale 1ns/1ns
`default_nettype none
module tick_event_source #(
  parameter int HALF = 20
) (
  input wire logic clk_i,
  input wire logic [2:0] fire_i,
  output logic tick_o,
  output logic timer_event_o,
  output logic alarm1_o,
  output logic alarm2_o
);
  int cnt = 0;
  logic prev = 1'b0;
  initial
  begin
    tick_o = 1'b0;
    timer_event_o = 1'b0;
    alarm1_o = 1'b0;
    alarm2_o = 1'b0;
  end
  // Short tick period keeps the run small
  always @(posedge clk_i)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      tick_o <= ~tick_o;
    prev <= fire_i[0];
    timer_event_o <= fire_i[0] && !prev;
    alarm1_o <= fire_i[1];
    alarm2_o <= fire_i[2];
  end
endmodule // tick_event_source
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the clock/calendar core
`timescale 1ns/1ns
`include "rtc_core_defines.vh"
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] paddr = 32'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] month = 8'h01;
  logic [7:0] year = 8'h00;
  logic [2:0] fire = 3'h0;
  logic [7:0] rv;
  logic [7:0] eb;
  wire pready, pslverr, tick, a1, a2, tev, roll, multipurpose_io, irq;
  wire [31:0] prdata;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rolls = 0;
  always #50 clk = ~clk;
  // Day rollover pulses seen by the bench
  always @(posedge clk)
  begin
    if (roll === 1'b1)
    begin
      rolls <= rolls + 1;
    end
  end
  tick_event_source #(.HALF(20)) i_tick_event_source (.clk_i(clk), .fire_i(fire),
    .tick_o(tick), .timer_event_o(tev), .alarm1_o(a1), .alarm2_o(a2));
  rtc_time_status_control i_rtc_time_status_control (.core_clk_i(clk), .srst_i(srst),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .one_hertz_tick_i(tick), .alarm1_match_i(a1), .alarm2_match_i(a2),
    .seconds_timer_event_i(tev), .month_i(month), .year_i(year),
    .day_rollover_o(roll), .multipurpose_io_o(multipurpose_io), .irq_o(irq));
  task automatic report_and_stop;
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    paddr <= {14'h0, a, 2'b00};
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    acc(a, 1'b0, 8'h00);
    chk(rv, exp);
  endtask
  // Restart right after a tick falls so the next rise is surely counted
  task automatic start_at(input logic [7:0] s);
    acc(`RTC_SEC_ADDR, 1'b1, s);
    @(negedge multipurpose_io);
    acc(`RTC_CS1_ADDR, 1'b1, 8'h00);
  endtask
  task automatic corr(input logic [15:0] a, input logic [7:0] w, m, y, e, input logic f);
    month <= m;
    year <= y;
    acc(a, 1'b1, w);
    rdc(a, e);
    rdc(`RTC_CS2_ADDR, {f, 7'h0});
    chk({7'h0, irq}, {7'h0, f});
    acc(`RTC_CS2_ADDR, 1'b1, 8'h00);
    chk({7'h0, irq}, 8'h00);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc(`RTC_SEC_ADDR, 8'h80);
    rdc(`RTC_MIN_ADDR, 8'h00);
    rdc(`RTC_HOUR_ADDR, 8'h00);
    rdc(`RTC_DAY_ADDR, 8'h01);
    rdc(`RTC_CS1_ADDR, 8'h10);
    rdc(`RTC_CS2_ADDR, 8'h00);
    rdc(16'h9108, 8'h00);
    repeat (2) @(posedge multipurpose_io);
    rdc(`RTC_SEC_ADDR, 8'h80);
    acc(`RTC_CS1_ADDR, 1'b1, 8'hEF);
    rdc(`RTC_CS1_ADDR, 8'h00);
    acc(`RTC_MIN_ADDR, 1'b1, 8'h05);
    rdc(`RTC_CS1_ADDR, 8'h10);
    $display("test reset and halt done");
    corr(`RTC_DAY_ADDR, 8'h00, 8'h01, 8'h00, 8'h01, 1'b1);
    corr(`RTC_DAY_ADDR, 8'h29, 8'h02, 8'h00, 8'h01, 1'b1);
    corr(`RTC_DAY_ADDR, 8'h29, 8'h02, 8'h04, 8'h29, 1'b0);
    corr(`RTC_DAY_ADDR, 8'h31, 8'h04, 8'h04, 8'h01, 1'b1);
    corr(`RTC_MIN_ADDR, 8'h60, 8'h01, 8'h00, 8'h00, 1'b1);
    corr(`RTC_HOUR_ADDR, 8'h1A, 8'h01, 8'h00, 8'h00, 1'b1);
    corr(`RTC_SEC_ADDR, 8'h5A, 8'h01, 8'h00, 8'h00, 1'b1);
    $display("test correction done");
    acc(`RTC_MIN_ADDR, 1'b1, 8'h59);
    acc(`RTC_HOUR_ADDR, 1'b1, 8'h23);
    acc(`RTC_DAY_ADDR, 1'b1, 8'h31);
    start_at(8'h59);
    @(posedge multipurpose_io);
    repeat (4) @(posedge clk);
    rdc(`RTC_SEC_ADDR, 8'h00);
    rdc(`RTC_MIN_ADDR, 8'h00);
    rdc(`RTC_HOUR_ADDR, 8'h00);
    rdc(`RTC_DAY_ADDR, 8'h01);
    chk(rolls[7:0], 8'h01);
    $display("test rollover done");
    for (int k = 0; k < 3; k++)
    begin
      for (int en = 0; en < 2; en++)
      begin
        eb = (en == 1) ? (8'h01 << k) : 8'h00;
        acc(`RTC_CS2_ADDR, 1'b1, eb);
        start_at(8'h59);
        fire <= 3'h1 << k;
        repeat (3) @(posedge clk);
        if (k > 0)
          rdc(`RTC_CS2_ADDR, eb);
        repeat (2) @(posedge multipurpose_io);
        fire <= 3'h0;
        repeat (4) @(posedge clk);
        rdc(`RTC_CS2_ADDR, eb | ((k == 0 || en == 1) ? (8'h08 << k) : 8'h00));
        chk({7'h0, irq}, eb >> k);
        if (k > 0 && en == 0)
        begin
          acc(`RTC_CS2_ADDR, 1'b1, 8'h01 << k);
          chk({7'h0, irq}, 8'h00);
        end
        acc(`RTC_CS2_ADDR, 1'b1, 8'h00);
        rdc(`RTC_CS2_ADDR, 8'h00);
        chk({7'h0, irq}, 8'h00);
      end
    end
    acc(`RTC_CS2_ADDR, 1'b1, 8'hF8);
    rdc(`RTC_CS2_ADDR, 8'h00);
    chk(rolls[7:0], 8'h01);
    $display("test flags done");
    report_and_stop();
  end
endmodule // tb
bind rtc_time_status_control rtc_chk i_rtc_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .one_hertz_tick_i(one_hertz_tick_i), .day_rollover_o(day_rollover_o),
  .multipurpose_io_o(multipurpose_io_o), .irq_o(irq_o));
`default_nettype wire
